/* File: rtl/tmr3_pkg.sv */
/*
 Package of the timer control and reload block: register addresses, field positions,
 reset values and prescaler counts.
 Assumes an 8-bit special function register port on the system clock.
*/
package tmr3_pkg;
	localparam logic [7:0] ADDR_CONTROL = 8'h91;
	localparam logic [7:0] ADDR_RELOAD_LOW = 8'h92;
	localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
	localparam logic [7:0] ADDR_COUNT_LOW = 8'h94;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'h95;
	localparam int BIT_UPPER_FLAG = 7;
	localparam int BIT_LOWER_FLAG = 6;
	localparam int BIT_LOWER_IRQ_EN = 5;
	localparam int BIT_CAPTURE_EN = 4;
	localparam int BIT_SPLIT = 3;
	localparam int BIT_RUN = 2;
	localparam int BIT_RESERVED = 1;
	localparam int BIT_EXT_CLK = 0;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] BYTE_MAX = 8'hFF;
	localparam int SYS_DIVIDE = 12;
	localparam int EXT_DIVIDE = 8;
	typedef enum logic [1:0] {TMR3_SRC_SYS, TMR3_SRC_EXT} tmr3_src_t;
endpackage

/* File: rtl/tmr3_tick_gen.sv */
/*
 Tick generator: system clock divided by twelve and synchronised external clock
 divided by eight, one-cycle ticks.
 Assumes extClock is asynchronous to clk.
*/
`timescale 1ns/1ps
module tmr3_tick_gen
	import tmr3_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// External clock pin
	input wire logic extClock,
	// Ticks
	output logic sysTick,
	output logic extTick
);
	logic [3:0] sysCnt_q;
	logic [2:0] extCnt_q;
	logic extSync1_q;
	logic extSync2_q;
	logic extPrev_q;
	logic extRise;

	// ************************************
	// Divided ticks
	// ************************************
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			sysCnt_q <= 4'h0;
		else if (sysCnt_q == 4'(SYS_DIVIDE - 1))
			sysCnt_q <= 4'h0;
		else
			sysCnt_q <= sysCnt_q + 4'h1;
	end
	assign sysTick = (sysCnt_q == 4'(SYS_DIVIDE - 1)); // RQ11

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			extSync1_q <= 1'b0;
			extSync2_q <= 1'b0;
			extPrev_q <= 1'b0;
		end
		else
		begin
			extSync1_q <= extClock;
			extSync2_q <= extSync1_q;
			extPrev_q <= extSync2_q;
		end
	end
	assign extRise = extSync2_q & ~extPrev_q;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			extCnt_q <= 3'h0;
		else if (extRise)
			extCnt_q <= extCnt_q + 3'h1;
	end
	assign extTick = extRise && (extCnt_q == 3'(EXT_DIVIDE - 1)); // RQ11
endmodule // tmr3_tick_gen

/* File: rtl/tmr3_control_reload.sv */
/*
 Timer control and reload logic: control register, reload pair, counter pair,
 split and 16-bit auto-reload, capture on falling low-frequency oscillator edge.
 Assumes a one-cycle SFR write/read port on clk; lfoClock and extClock are asynchronous.
*/
// How it works
// RQ1 - Upper byte wrap sets upper flag
// RQ2 - 16-bit wrap sets upper flag
// RQ3 - Upper flag requests interrupt when enabled
// RQ4 - Flags cleared only by software writing zero
// RQ5 - Lower byte wrap sets lower flag always
// RQ6 - Lower flag interrupts when lower enable set
// RQ7 - Capture copies counter on oscillator falling edge
// RQ8 - Split bit selects 16-bit or two 8-bit
// RQ9 - Run gates counting; split gates upper only
// RQ10 - Reserved bit reads zero
// RQ11 - Clock select: system_clock/12 or external/8
// RQ12 - Per-byte selects choose every-cycle system clock or the selected tick
// RQ13 - Reload low feeds lower byte reload
// RQ14 - Capture mode stores lower byte in reload low
// RQ15 - Reload high feeds/captures upper byte
// RQ16 - Counter bytes hold count halves
// RQ17 - Overflow reloads counter on same step
`timescale 1ns/1ps
module tmr3_control_reload
	import tmr3_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic regWrite,
	input wire logic [7:0] regWriteData,
	output logic [7:0] regReadData,
	// Clock sources and per-byte selects
	input wire logic extClock,
	input wire logic lfoClock,
	input wire logic upperByteClockSelect,
	input wire logic lowerByteClockSelect,
	// Interrupt
	input wire logic timerIrqEnable,
	output logic timerIrq
);
	logic [7:0] control_q;
	logic [7:0] reloadLow_q;
	logic [7:0] reloadHigh_q;
	logic [7:0] countLow_q;
	logic [7:0] countHigh_q;
	logic lfoSync1_q;
	logic lfoSync2_q;
	logic lfoPrev_q;
	logic captureEvent_q;
	logic sysTick;
	logic extTick;
	logic ovfLow;
	logic ovfHigh;
	logic stepLow;
	logic stepHigh;
	logic lfoFall;
	logic [7:0] readMux;

	function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target, input logic we);
		wr_hit = we && (a == target);
	endfunction

	tmr3_tick_gen u_tick
	(
		.clk(clk),
		.reset(reset),
		.extClock(extClock),
		.sysTick(sysTick),
		.extTick(extTick)
	);

	// ************************************
	// Count steps and overflows
	// ************************************
	logic tickSrc;
	logic splitMode;
	logic runBit;
	assign tickSrc = control_q[BIT_EXT_CLK] ? extTick : sysTick; // RQ11
	assign splitMode = control_q[BIT_SPLIT]; // RQ8
	assign runBit = control_q[BIT_RUN];
	always_comb
	begin
		if (splitMode)
		begin
			stepLow = lowerByteClockSelect ? 1'b1 : tickSrc; // RQ12 RQ9
			stepHigh = runBit && (upperByteClockSelect ? 1'b1 : tickSrc); // RQ12 RQ9
		end
		else
		begin
			stepLow = runBit && (lowerByteClockSelect ? 1'b1 : tickSrc); // RQ9
			stepHigh = stepLow && (countLow_q == BYTE_MAX);
		end
	end
	assign ovfLow = stepLow && (countLow_q == BYTE_MAX); // RQ5
	assign ovfHigh = stepHigh && (countHigh_q == BYTE_MAX); // RQ1 RQ2

	// ************************************
	// Capture edge detect
	// ************************************
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			lfoSync1_q <= 1'b0;
			lfoSync2_q <= 1'b0;
			lfoPrev_q <= 1'b0;
		end
		else
		begin
			lfoSync1_q <= lfoClock;
			lfoSync2_q <= lfoSync1_q;
			lfoPrev_q <= lfoSync2_q;
		end
	end
	assign lfoFall = lfoPrev_q & ~lfoSync2_q & control_q[BIT_CAPTURE_EN]; // RQ7

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			captureEvent_q <= 1'b0;
		else
			captureEvent_q <= lfoFall;
	end

	// ************************************
	// Control register
	// ************************************
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			control_q <= CONTROL_RESET;
		else
		begin
			if (wr_hit(regAddr, ADDR_CONTROL, regWrite))
			begin
				control_q <= regWriteData;
				control_q[BIT_RESERVED] <= 1'b0; // RQ10
			end
			if (ovfHigh)
				control_q[BIT_UPPER_FLAG] <= 1'b1; // RQ1 RQ2 RQ4
			if (ovfLow)
				control_q[BIT_LOWER_FLAG] <= 1'b1; // RQ5 RQ4
		end
	end

	// ************************************
	// Reload pair
	// ************************************
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			reloadLow_q <= BYTE_RESET;
			reloadHigh_q <= BYTE_RESET;
		end
		else if (lfoFall)
		begin
			reloadLow_q <= countLow_q; // RQ14 RQ7
			reloadHigh_q <= countHigh_q; // RQ15 RQ7
		end
		else
		begin
			if (wr_hit(regAddr, ADDR_RELOAD_LOW, regWrite))
				reloadLow_q <= regWriteData;
			if (wr_hit(regAddr, ADDR_RELOAD_HIGH, regWrite))
				reloadHigh_q <= regWriteData;
		end
	end

	// ************************************
	// Counter pair
	// ************************************
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			countLow_q <= BYTE_RESET;
		else if (wr_hit(regAddr, ADDR_COUNT_LOW, regWrite))
			countLow_q <= regWriteData; // RQ16
		else if (stepLow)
		begin
			if (countLow_q != BYTE_MAX)
				countLow_q <= countLow_q + 8'h01;
			else if (splitMode)
				countLow_q <= reloadLow_q; // RQ13 RQ17
			else if (countHigh_q == BYTE_MAX)
				countLow_q <= reloadLow_q; // RQ13 RQ17
			else
				countLow_q <= BYTE_RESET;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			countHigh_q <= BYTE_RESET;
		else if (wr_hit(regAddr, ADDR_COUNT_HIGH, regWrite))
			countHigh_q <= regWriteData; // RQ16
		else if (stepHigh)
		begin
			if (countHigh_q == BYTE_MAX)
				countHigh_q <= reloadHigh_q; // RQ15 RQ17
			else
				countHigh_q <= countHigh_q + 8'h01;
		end
	end

	// ************************************
	// Read port and interrupt
	// ************************************
	always_comb
	begin
		unique case (regAddr)
			ADDR_CONTROL: readMux = control_q & ~(8'h01 << BIT_RESERVED); // RQ10
			ADDR_RELOAD_LOW: readMux = reloadLow_q;
			ADDR_RELOAD_HIGH: readMux = reloadHigh_q;
			ADDR_COUNT_LOW: readMux = countLow_q;
			ADDR_COUNT_HIGH: readMux = countHigh_q;
			default: readMux = 8'h00;
		endcase
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			regReadData <= 8'h00;
		else
			regReadData <= readMux;
	end

	// RQ3 RQ6 RQ7
	assign timerIrq = timerIrqEnable && (control_q[BIT_UPPER_FLAG]
		|| (control_q[BIT_LOWER_IRQ_EN] && control_q[BIT_LOWER_FLAG]) || captureEvent_q);

	// ************************************
	// Checks
	// ************************************
	a_upper_flag_set: assert property (@(posedge clk) disable iff (reset) ovfHigh |=> control_q[BIT_UPPER_FLAG]) // RQ1
		else $error("upper flag not set on overflow");
	a_wide_wrap: assert property (@(posedge clk) disable iff (reset)
		(!splitMode && stepLow && countLow_q == 8'hFF && countHigh_q == 8'hFF) |=> control_q[BIT_UPPER_FLAG]) // RQ2
		else $error("16-bit wrap missed");
	a_upper_irq: assert property (@(posedge clk) disable iff (reset)
		(timerIrqEnable && control_q[BIT_UPPER_FLAG]) |-> timerIrq) // RQ3
		else $error("upper irq missing");
	a_flag_sticky: assert property (@(posedge clk) disable iff (reset)
		(control_q[BIT_LOWER_FLAG] && !(regWrite && regAddr == ADDR_CONTROL)) |=> control_q[BIT_LOWER_FLAG]) // RQ4
		else $error("lower flag cleared by hardware");
	a_lower_flag_set: assert property (@(posedge clk) disable iff (reset) ovfLow |=> control_q[BIT_LOWER_FLAG]) // RQ5
		else $error("lower flag not set");
	a_lower_irq: assert property (@(posedge clk) disable iff (reset)
		(timerIrqEnable && control_q[BIT_LOWER_IRQ_EN] && control_q[BIT_LOWER_FLAG]) |-> timerIrq) // RQ6
		else $error("lower irq missing");
	a_capture_copy: assert property (@(posedge clk) disable iff (reset)
		lfoFall |=> (reloadLow_q == $past(countLow_q) && reloadHigh_q == $past(countHigh_q))) // RQ7
		else $error("capture copy wrong");
	a_split_low_runs: assert property (@(posedge clk) disable iff (reset)
		(splitMode && !runBit && ovfLow && !(regWrite && regAddr == ADDR_COUNT_LOW)) |=> countLow_q == $past(reloadLow_q)) // RQ9
		else $error("split low reload wrong");
	a_reserved_zero: assert property (@(posedge clk) disable iff (reset) !control_q[BIT_RESERVED]) // RQ10
		else $error("reserved bit set");
	c_capture: cover property (@(posedge clk) disable iff (reset) lfoFall);
	c_split_ovf: cover property (@(posedge clk) disable iff (reset) splitMode && ovfHigh);
	c_wide_ovf: cover property (@(posedge clk) disable iff (reset) !splitMode && ovfHigh);
endmodule // tmr3_control_reload

/* File: dv/test_tmr3_control_reload.sv */
/*
 Self-checking testbench of the timer control and reload block.
 Assumes the timer package and design modules are compiled first.
*/
`timescale 1ns/1ps
module test_tmr3_control_reload;
	import tmr3_pkg::*;
	// ****************
	// Signals
	// ****************
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic regWrite = 1'b0;
	logic extClock = 1'b0;
	logic lfoClock = 1'b0;
	logic upSel = 1'b1;
	logic loSel = 1'b1;
	logic irqEn = 1'b0;
	logic timerIrq;
	logic rdV = 1'b0;
	logic rdD = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWriteData = 8'h00;
	logic [7:0] regReadData;
	logic [7:0] v;
	logic [15:0] q[$];
	logic [31:0] lf = 32'h0001_088B;
	int n_errors = 0;
	int total_checks = 0;
	int irqCnt = 0;
	int c0;
	tmr3_control_reload i_dut (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrite(regWrite),
		.regWriteData(regWriteData), .regReadData(regReadData), .extClock(extClock), .lfoClock(lfoClock),
		.upperByteClockSelect(upSel), .lowerByteClockSelect(loSel), .timerIrqEnable(irqEn), .timerIrq(timerIrq));
	always #2 clk = ~clk;
	// External clock edges kept off the system clock edges
	initial
	begin
		#0.25;
		forever #20.5 extClock = ~extClock;
	end
	// ****************
	// Tasks
	// ****************
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrite <= 1'b1;
		regWriteData <= d;
		rdV <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		regAddr <= a;
		regWrite <= 1'b0;
		rdV <= 1'b1;
		q.push_back({a, e});
	endtask
	task automatic idle(input int n);
		@(posedge clk);
		regWrite <= 1'b0;
		rdV <= 1'b0;
		repeat (n) @(posedge clk);
	endtask
	task automatic chkIrq(input logic e);
		idle(3);
		@(negedge clk);
		chk("timerIrq", {7'h00, e}, {7'h00, timerIrq});
	endtask
	// Runs the counter from zero for n cycles and expects 20 or 21 steps
	task automatic meas(input logic [7:0] ctl, input int n);
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_COUNT_LOW, 8'h00);
		wr(ADDR_COUNT_HIGH, 8'h00);
		wr(ADDR_CONTROL, ctl);
		idle(n);
		wr(ADDR_CONTROL, ctl & 8'h01);
		@(posedge clk);
		regAddr <= ADDR_COUNT_LOW;
		regWrite <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		v = regReadData;
		total_checks++;
		if (!(v >= 8'h14 && v <= 8'h15))
		begin
			n_errors++;
			$display("[ERR] count after %0d cycles expected 14 to 15 seen %h", n, v);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ****************
	// Monitor
	// ****************
	always @(posedge clk)
	begin
		rdD <= rdV;
	end
	always @(negedge clk)
	begin
		if (timerIrq === 1'b1)
			irqCnt <= irqCnt + 1;
		if (rdD && q.size() > 0)
		begin
			logic [15:0] e;
			e = q.pop_front();
			chk($sformatf("register %h", e[15:8]), e[7:0], regReadData);
		end
	end
	initial
	begin
		#200000;
		n_errors++;
		$display("[ERR] run time expected end of sequence seen limit");
		stop_test();
	end
	// ****************
	// Sequence
	// ****************
	initial
	begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		for (int a = 8'h90; a <= 8'h96; a++) rd(8'(a), 8'h00);
		wr(ADDR_CONTROL, 8'h02);
		rd(ADDR_CONTROL, 8'h00);
		lf = nxt(lf);
		wr(ADDR_RELOAD_LOW, lf[7:0]);
		wr(ADDR_RELOAD_HIGH, lf[15:8]);
		rd(ADDR_RELOAD_LOW, lf[7:0]);
		rd(ADDR_RELOAD_HIGH, lf[15:8]);
		$display("test registers done");
		wr(ADDR_RELOAD_LOW, 8'hFF);
		wr(ADDR_COUNT_HIGH, 8'h10);
		wr(ADDR_CONTROL, 8'h08);
		irqEn <= 1'b1;
		idle(300);
		rd(ADDR_COUNT_LOW, 8'hFF);
		rd(ADDR_COUNT_HIGH, 8'h10);
		rd(ADDR_CONTROL, 8'h48);
		chkIrq(1'b0);
		wr(ADDR_CONTROL, 8'h28);
		chkIrq(1'b1);
		wr(ADDR_RELOAD_HIGH, 8'hFF);
		wr(ADDR_CONTROL, 8'h0C);
		idle(300);
		rd(ADDR_COUNT_HIGH, 8'hFF);
		rd(ADDR_CONTROL, 8'hCC);
		$display("test split done");
		wr(ADDR_CONTROL, 8'h04);
		idle(4);
		rd(ADDR_COUNT_LOW, 8'hFF);
		rd(ADDR_COUNT_HIGH, 8'hFF);
		rd(ADDR_CONTROL, 8'hC4);
		chkIrq(1'b1);
		irqEn <= 1'b0;
		chkIrq(1'b0);
		wr(ADDR_CONTROL, 8'h00);
		idle(20);
		rd(ADDR_CONTROL, 8'hC0);
		wr(ADDR_CONTROL, 8'h00);
		rd(ADDR_CONTROL, 8'h00);
		$display("test wide done");
		lf = nxt(lf);
		wr(ADDR_COUNT_LOW, lf[7:0]);
		wr(ADDR_COUNT_HIGH, lf[15:8]);
		wr(ADDR_CONTROL, 8'h10);
		irqEn <= 1'b1;
		lfoClock <= 1'b1;
		idle(6);
		c0 = irqCnt;
		lfoClock <= 1'b0;
		idle(8);
		chk("capture pulse", 8'h01, 8'(irqCnt - c0));
		rd(ADDR_RELOAD_LOW, lf[7:0]);
		rd(ADDR_RELOAD_HIGH, lf[15:8]);
		$display("test capture done");
		upSel <= 1'b0;
		loSel <= 1'b0;
		meas(8'h04, 240);
		meas(8'h05, 1640);
		meas(8'h0D, 1640);
		$display("test clock source done");
		idle(10);
		chk("pending reads", 8'h00, 8'(q.size()));
		stop_test();
	end
endmodule // test_tmr3_control_reload
